// [src/ctb_unit.v]
// Decode/execute unit for compact flag branches, XOR compares and signed divide
`timescale 1ns/1ps
`include "ctb_regs.vh"
module ctb_unit #(
  parameter XLEN = 32
) (
  input  wire            sys_clk,
  input  wire            arst_n,
  input  wire            clkEn,
  input  wire            instValid,
  input  wire [31:0]     instWord,
  input  wire            instExtended,
  input  wire [31:0]     instAddr,
  input  wire [XLEN-1:0] srcA,
  input  wire [XLEN-1:0] srcB,
  input  wire [XLEN-1:0] flagValue,
  input  wire            quoRemRead,
  output wire [4:0]      srcAIndex,
  output wire [4:0]      srcBIndex,
  output wire            instReady,
  output wire            quoRemStall,
  output reg             redirect,
  output reg  [31:0]     redirectTarget,
  output reg             flagWrite,
  output reg  [4:0]      flagWriteIndex,
  output reg  [XLEN-1:0] flagWriteData,
  output reg  [XLEN-1:0] quotient_register,
  output reg  [XLEN-1:0] remainder_register,
  output reg             divBusy,
  output reg             divDone
);

  // Compact 3-bit field to architectural register (16,17,2..7)
  function [4:0] xlatReg;
    input [2:0] field;
    begin
      xlatReg = (field[2:1] == 2'b00) ? {4'h8, field[0]} : {2'b00, field};
    end
  endfunction

  wire [15:0] op = instWord[15:0];
  wire [4:0]  major = op[`CTB_MAJOR_HI:`CTB_MAJOR_LO];
  wire [2:0]  sub = op[`CTB_SUB_HI:`CTB_SUB_LO];
  wire [4:0]  func = op[`CTB_FUNC_HI:`CTB_FUNC_LO];
  wire        extOk = instExtended && (instWord[`CTB_EXT_HI:`CTB_EXT_LO] == `CTB_EXTEND_PREFIX);
  wire        extZeroGap = (op[7:5] == 3'h0);
  // Extended 16-bit field from three slices
  wire [15:0] extField = {instWord[20:16], instWord[26:21], instWord[4:0]};

  wire isBrShort = !instExtended && (major == `CTB_IMM_BYTE_MAJOR);
  wire isBrExt   = extOk && extZeroGap && (major == `CTB_IMM_BYTE_MAJOR);
  wire isBrZero  = (isBrShort || isBrExt) && (sub == `CTB_SUB_FLAG_ZERO);
  wire isBrNz    = (isBrShort || isBrExt) && (sub == `CTB_SUB_FLAG_NZ);
  wire isRegOp   = !instExtended && (major == `CTB_REG_OP_MAJOR);
  wire isCmpReg  = isRegOp && (func == `CTB_FUNC_XOR_CMP);
  wire isDiv     = isRegOp && (func == `CTB_FUNC_SDIV);
  wire isCmpImmS = !instExtended && (major == `CTB_XOR_IMM_MAJOR);
  wire isCmpImmE = extOk && extZeroGap && (major == `CTB_XOR_IMM_MAJOR);

  assign srcAIndex = xlatReg(op[`CTB_RX_HI:`CTB_RX_LO]);
  assign srcBIndex = xlatReg(op[`CTB_RY_HI:`CTB_RY_LO]);

  // Offset shifted by one: halfword units
  wire [31:0] offShort = {{23{op[7]}}, op[7:0], 1'b0};
  wire [31:0] offExt   = {{15{extField[15]}}, extField, 1'b0};
  wire [31:0] nextTarget = isBrExt ? (instAddr + `CTB_LONG_STEP + offExt)
                                   : (instAddr + `CTB_SHORT_STEP + offShort);
  wire flagIsZero = (flagValue == {XLEN{1'b0}});
  wire takeBranch = (isBrZero && flagIsZero) || (isBrNz && !flagIsZero);

  reg [XLEN-1:0] next_cmp;
  always @* begin
    if (isCmpReg)
      next_cmp = srcA ^ srcB;
    else if (isCmpImmE)
      next_cmp = srcA ^ {{(XLEN-16){1'b0}}, extField};
    else
      next_cmp = srcA ^ {{(XLEN-8){1'b0}}, op[7:0]};
  end

  // Iterative restoring divide on magnitudes; one bit per cycle.
  // Fixed latency keeps the interlock simple; no early exit on small operands.
  reg  [XLEN-1:0] divRem;
  reg  [XLEN-1:0] divQuo;
  reg  [XLEN-1:0] divDivisor;
  reg             negQuo;
  reg             negRem;
  reg  [5:0]      divCount;

  // Two's complement negate, shared by operand and result sign fix-up
  function [XLEN-1:0] negate;
    input [XLEN-1:0] value;
    begin
      negate = ~value + {{(XLEN-1){1'b0}}, 1'b1};
    end
  endfunction

  wire [XLEN:0]   trial     = {divRem, divQuo[XLEN-1]} - {1'b0, divDivisor};
  wire            trialFits = !trial[XLEN];
  // Most negative operand maps to itself; as unsigned magnitude it still fits
  wire [XLEN-1:0] magA      = srcA[XLEN-1] ? negate(srcA) : srcA;
  wire [XLEN-1:0] magB      = srcB[XLEN-1] ? negate(srcB) : srcB;

  // One step: keep the difference only when the divisor fits
  reg  [XLEN-1:0] next_divRem;
  reg  [XLEN-1:0] next_divQuo;
  always @* begin
    if (trialFits) begin
      next_divRem = trial[XLEN-1:0];
    end else begin
      next_divRem = {divRem[XLEN-2:0], divQuo[XLEN-1]};
    end
    next_divQuo = {divQuo[XLEN-2:0], trialFits};
  end

  // Sign fix-up on the final step's magnitudes
  wire [XLEN-1:0] resultQuo = negQuo ? negate(next_divQuo) : next_divQuo;
  wire [XLEN-1:0] resultRem = negRem ? negate(next_divRem) : next_divRem;
  wire            lastStep  = (divCount == 6'h01);

  // A new divide waits for the previous one; reads stall while busy
  assign instReady   = !(divBusy && isDiv && instValid);
  assign quoRemStall = divBusy && quoRemRead;

  // Producer must hold an instruction until an enabled, ready edge takes it
  wire accept   = clkEn && instValid && instReady;
  wire isBranch = isBrZero || isBrNz;
  wire isCmpAny = isCmpReg || isCmpImmS || isCmpImmE;

  // Branch redirect: one-cycle pulse plus held target
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      redirect       <= 1'b0;
      redirectTarget <= 32'h00000000;
    end else if (clkEn) begin
      redirect <= accept && takeBranch;
      if (accept && isBranch) begin
        redirectTarget <= nextTarget;
      end
    end
  end

  // Flag write-back; fixed index, so no other register is touched
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      flagWrite      <= 1'b0;
      flagWriteIndex <= 5'h00;
      flagWriteData  <= {XLEN{1'b0}};
    end else if (clkEn) begin
      flagWrite <= accept && isCmpAny;
      if (accept && isCmpAny) begin
        flagWriteIndex <= `CTB_FLAG_REG;
        flagWriteData  <= next_cmp;
      end
    end
  end

  // Divider sequencing and result registers
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      quotient_register  <= {XLEN{1'b0}};
      remainder_register <= {XLEN{1'b0}};
      divBusy            <= 1'b0;
      divDone            <= 1'b0;
      divRem             <= {XLEN{1'b0}};
      divQuo             <= {XLEN{1'b0}};
      divDivisor         <= {XLEN{1'b0}};
      negQuo             <= 1'b0;
      negRem             <= 1'b0;
      divCount           <= 6'h00;
    end else if (clkEn) begin
      divDone <= 1'b0;
      if (accept && isDiv) begin
        divBusy    <= 1'b1;
        divRem     <= {XLEN{1'b0}};
        divQuo     <= magA;
        divDivisor <= magB;
        negQuo     <= srcA[XLEN-1] ^ srcB[XLEN-1];
        negRem     <= srcA[XLEN-1];
        divCount   <= `CTB_DIV_STEPS;
      end else if (divBusy) begin
        // Zero divisor just runs out: no trap, result meaningless
        divRem   <= next_divRem;
        divQuo   <= next_divQuo;
        divCount <= divCount - 6'h01;
        if (lastStep) begin
          divBusy            <= 1'b0;
          divDone            <= 1'b1;
          quotient_register  <= resultQuo;
          remainder_register <= resultRem;
        end
      end
    end
  end

endmodule // ctb_unit

// [src/ctb_regs.vh]
// Encodings, field positions and constants of the compact branch/compare/divide unit
`ifndef CTB_REGS_VH
`define CTB_REGS_VH
`define CTB_MAJOR_HI        15
`define CTB_MAJOR_LO        11
`define CTB_SUB_HI          10
`define CTB_SUB_LO          8
`define CTB_RX_HI           10
`define CTB_RX_LO           8
`define CTB_RY_HI           7
`define CTB_RY_LO           5
`define CTB_FUNC_HI         4
`define CTB_FUNC_LO         0
`define CTB_EXT_HI          31
`define CTB_EXT_LO          27
`define CTB_EXTEND_PREFIX   5'h1e
`define CTB_IMM_BYTE_MAJOR  5'h0c
`define CTB_XOR_IMM_MAJOR   5'h0e
`define CTB_REG_OP_MAJOR    5'h1d
`define CTB_SUB_FLAG_ZERO   3'h0
`define CTB_SUB_FLAG_NZ     3'h1
`define CTB_FUNC_XOR_CMP    5'h0a
`define CTB_FUNC_SDIV       5'h1a
`define CTB_FLAG_REG        5'h18
`define CTB_SHORT_STEP      32'h00000002
`define CTB_LONG_STEP       32'h00000004
`define CTB_DIV_STEPS       6'h20
`endif

// [bench/ctb_rf_model.sv]
// Register file stand-in: operand reads and flag register write-back
`timescale 1ns/1ps
module ctb_rf_model (
  input  wire        sys_clk,
  input  wire [4:0]  srcAIndex,
  input  wire [4:0]  srcBIndex,
  input  wire        flagWrite,
  input  wire [4:0]  flagWriteIndex,
  input  wire [31:0] flagWriteData,
  output wire [31:0] srcA,
  output wire [31:0] srcB,
  output wire [31:0] flagValue
);
  logic [31:0] gpr [0:31];
  assign srcA = gpr[srcAIndex];
  assign srcB = gpr[srcBIndex];
  assign flagValue = gpr[24];
  always @(posedge sys_clk) begin
    if (flagWrite) gpr[flagWriteIndex] <= flagWriteData;
  end
endmodule // ctb_rf_model

// [bench/ctb_unit_chk.sv]
// Port assertions for the flag branch, XOR compare and divide unit
`timescale 1ns/1ps
module ctb_unit_chk #(parameter XLEN = 32) (
  input wire sys_clk, arst_n, clkEn, instValid, instExtended, instReady, quoRemRead,
  input wire quoRemStall, redirect, flagWrite, divBusy, divDone,
  input wire [31:0] instWord, instAddr, redirectTarget,
  input wire [XLEN-1:0] srcA, srcB, flagValue, flagWriteData,
  input wire [4:0] srcAIndex, flagWriteIndex
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  wire       go = clkEn && instValid && instReady;
  wire [7:0] op = instWord[15:8];
  reg [31:0] tgt;
  always @(posedge sys_clk) tgt <= instAddr + 32'h2 + {{23{instWord[7]}}, instWord[7:0], 1'b0};
  a_stall_follows: assert property (quoRemStall == (divBusy && quoRemRead))
    else $error("stall wrong");
  a_div_span: assert property ($rose(divBusy) |-> divBusy[*8] ##[23:25] divDone)
    else $error("divide span wrong");
  a_zero_taken: assert property (go && op == 8'h60 && flagValue == 0 |=> redirect)
    else $error("zero branch not taken");
  a_zero_held: assert property (go && op == 8'h60 && flagValue != 0 |=> !redirect)
    else $error("zero branch wrongly taken");
  a_nz_taken: assert property (go && op == 8'h61 && flagValue != 0 |=> redirect)
    else $error("nonzero branch not taken");
  a_short_target: assert property (go && !instExtended && instWord[15:9] == 7'h30
    |=> redirectTarget == tgt) else $error("short target wrong");
  a_cmp_write: assert property (go && !instExtended && instWord[15:11] == 5'h1d
    && instWord[4:0] == 5'h0a |=> flagWrite && flagWriteIndex == 5'h18
    && flagWriteData == ($past(srcA) ^ $past(srcB))) else $error("compare write wrong");
  a_index_xlat: assert property (srcAIndex == (instWord[10:9] == 2'h0 ?
    {4'h8, instWord[8]} : {2'h0, instWord[10:8]})) else $error("index wrong");
endmodule // ctb_unit_chk
bind ctb_unit ctb_unit_chk #(.XLEN(XLEN)) u_chk (.*);

// [bench/compact_isa_tbranch_cmp_div_bench.sv]
// Self-checking bench for the flag branch, XOR compare and divide unit
`timescale 1ns/1ps
module compact_isa_tbranch_cmp_div_bench;
  logic        sys_clk = 0, arst_n = 0, clkEn = 1, instValid = 0, instExtended = 0, quoRemRead = 0;
  logic [31:0] instWord = 0, instAddr = 0, r = 32'h4e8e, f, t;
  logic [15:0] o;
  logic [2:0]  x, y;
  logic        sb;
  wire  [31:0] srcA, srcB, flagValue, redirectTarget, flagWriteData;
  wire  [31:0] quotient_register, remainder_register;
  wire  [4:0]  srcAIndex, srcBIndex, flagWriteIndex;
  wire         instReady, quoRemStall, redirect, flagWrite, divBusy, divDone;
  logic [31:0] q[$];
  int          fails = 0, checks_done = 0;
  always #25 sys_clk = ~sys_clk;
  ctb_unit uut (.*);
  ctb_rf_model rf (.*);
  function [31:0] lf(input [31:0] s);
    lf = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function [31:0] g(input [2:0] i);
    g = rf.gpr[i < 3'h2 ? {4'h8, i[0]} : {2'h0, i}];
  endfunction
  function [31:0] pop;
    pop = q.size() ? q.pop_front() : 32'hx;
  endfunction
  task chk(input [31:0] seen, input [31:0] want);
    checks_done++;
    if (seen !== want) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task op(input [31:0] iw, input ie, input int gap);
    @(posedge sys_clk);
    instValid <= 1;
    instWord <= iw;
    instExtended <= ie;
    instAddr <= t;
    quoRemRead <= r[9];
    @(posedge sys_clk);
    instValid <= 0;
    repeat (gap) @(posedge sys_clk);
  endtask
  always @(negedge sys_clk) if (arst_n) begin
    if (redirect) chk(redirectTarget, pop());
    if (flagWrite) chk(flagWriteData, pop());
    if (divDone) chk(quotient_register, pop());
    if (divDone) chk(remainder_register, pop());
  end
  initial begin
    repeat (2000) @(posedge sys_clk);
    fails++;
    test_done;
  end
  initial begin
    for (int k = 0; k < 32; k++) begin
      r = lf(r);
      rf.gpr[k] = r;
    end
    repeat (10) @(posedge sys_clk);
    arst_n <= 1;
    for (int k = 0; k < 16; k++) begin
      r = lf(r);
      x = r[2:0];
      y = k < 4 ? x : r[5:3];
      o = r[31:16];
      sb = r[6];
      f = (k < 4 || k[0]) ? g(x) ^ g(y) : g(x) ^ (k[1] ? {16'h0, o} : {24'h0, o[7:0]});
      q.push_back(f);
      if (k < 4 || k[0]) op({16'h0, 5'h1d, x, y, 5'h0a}, 0, 3);
      else if (k[1]) op({5'h1e, o[10:5], o[15:11], 5'h0e, x, 3'h0, o[4:0]}, 1, 3);
      else op({16'h0, 5'h0e, x, o[7:0]}, 0, 3);
      t = lf(r) & 32'hfffffffe;
      if ((f == 0) ^ sb) q.push_back(r[7] ? t + 32'h4 + {{15{o[15]}}, o, 1'b0}
                                         : t + 32'h2 + {{23{o[7]}}, o[7:0], 1'b0});
      op(r[7] ? {5'h1e, o[10:5], o[15:11], 5'h0c, 2'h0, sb, 3'h0, o[4:0]}
              : {16'h0, 5'h0c, 2'h0, sb, o[7:0]}, r[7], 1);
    end
    // Clock enable low: a presented compare must leave no result behind
    clkEn <= 0;
    op({16'h0, 5'h1d, 3'h2, 3'h3, 5'h0a}, 0, 2);
    clkEn <= 1;
    $display("branch and compare test done");
    for (int k = 0; k < 4; k++) begin
      r = lf(r);
      x = r[2:0];
      y = r[5:3];
      // Shift-register values are never zero, so no divisor is zero
      q.push_back($signed(g(x)) / $signed(g(y)));
      q.push_back($signed(g(x)) % $signed(g(y)));
      op({16'h0, 5'h1d, x, y, 5'h1a}, 0, 34);
    end
    $display("divide test done");
    chk(32'(q.size()), 32'h0);
    test_done;
  end
endmodule // compact_isa_tbranch_cmp_div_bench
